//--- ppf_defs.svh
// Constants for the port 2 pull-up and port 3 function-select block.
// Assumes an 8-bit register address plus one bank-select bit from the CPU.
`ifndef PPF_DEFS_SVH
`define PPF_DEFS_SVH

`define PPF_ADDR_P2_PULLUP 8'hee
`define PPF_BANK_P2_PULLUP 1'b0
`define PPF_ADDR_P3_DATA 8'he3
`define PPF_BANK_P3_DATA 1'b0
`define PPF_ADDR_P3_CTRL 8'hef
`define PPF_BANK_P3_CTRL 1'b0
`define PPF_ADDR_P3_PIN45 8'he1
`define PPF_BANK_P3_PIN45 1'b1

`define PPF_RST_P2_PULLUP 8'h00
`define PPF_RST_P3_CTRL 8'h00
`define PPF_RST_P3_DATA 8'h00
`define PPF_RST_P3_PIN45 8'h50

`define PPF_CTRL_PKG_HI 7
`define PPF_CTRL_PKG_LO 6
`define PPF_CTRL_P1_FUNC 5
`define PPF_CTRL_P1_MODE_HI 4
`define PPF_CTRL_P1_MODE_LO 3
`define PPF_CTRL_P0_FUNC 2
`define PPF_CTRL_P0_MODE_HI 1
`define PPF_CTRL_P0_MODE_LO 0
`define PPF_PKG_SMALL 2'h0

`define PPF_DATA_CARRIER 7
`define PPF_DATA_UNUSED 6
`define PPF_DATA_MASK 8'hbf
`define PPF_PIN45_MASK 8'hf1

`define PPF_MODE_IN 2'h0
`define PPF_MODE_OD 2'h1
`define PPF_MODE_PP 2'h2
`define PPF_MODE_IN_PU 2'h3

`endif

//--- ppf_pkg.sv
// Types shared by the port configuration block.
// Assumes nothing beyond the constants header.
package ppf_pkg;
	typedef logic [1:0] ppf_mode_t;
	typedef logic [7:0] ppf_byte_t;
endpackage

//--- ppf_pin_drive.sv
// Pin driver decode: turns a two-bit mode and a data bit into pad controls.
// Assumes the pad resolves open drain from the output enable.
`include "ppf_defs.svh"
module ppf_pin_drive
	import ppf_pkg::*;
(
	input wire ppf_mode_t i_mode,
	input wire logic i_data,
	input wire logic i_alt_en,
	input wire logic i_alt_data,
	output logic o_out,
	output logic o_oe,
	output logic o_pullup,
	output logic o_is_output
);
	wire logic bit_val;
	wire logic is_od;
	wire logic is_pp;

	assign bit_val = i_alt_en ? i_alt_data : i_data;
	assign is_od = (i_mode == `PPF_MODE_OD);
	assign is_pp = (i_mode == `PPF_MODE_PP);
	// Open drain pulls low only; a high level is left to the wire.
	assign o_out = is_pp ? bit_val : 1'b0;
	assign o_oe = is_pp | (is_od & ~bit_val);
	assign o_pullup = (i_mode == `PPF_MODE_IN_PU);
	assign o_is_output = is_od | is_pp;
endmodule

//--- ppf_port_cfg.sv
// Port 2 pull-up enables and port 3 control, data and pin 4/5 registers.
// Assumes single-cycle register strobes on I_REF_CLK from the CPU core.
//
// Overview of operation
// R1: Each port 2 pull-up bit enables its own pin pull-up, bits 0 to 7.
// R2: Port 2 pull-up register is read/write at EEh, set 1 bank 0.
// R3: Port 3 pins 2 and 3 are always inputs with pull-up connected.
// R4: Control bits 7:6 pick small or large pin arrangement of functions.
// R5: Bit 5 and bit 2 enable alternate functions on pins 1 and 0.
// R6: Bits 1:0 and 4:3 set pin modes: input, drain, push, pulled input.
// R7: Port 3 data sits at E3h; bit 7 switches the carrier on.
// R8: Data bit 6 has no function and reads zero.
// R9: Data bits 1:0 read pins 1 and 0, alternate functions included.
// R10: Pins 4 and 5 are set up by the pin 4/5 register at E1h bank 1.
// R11: Pin 4/5 register resets to 50h, pin 4 starts open drain.
// R12: Configuration registers other than pin 4/5 reset to zero; writes act from their edge.
`include "ppf_defs.svh"
module ppf_port_cfg
	import ppf_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic I_REG_BANK,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [7:0] I_REG_WDATA,
	output logic [7:0] O_REG_RDATA,
	output logic O_REG_HIT,
	output logic [7:0] O_P2_PULLUP,
	input wire logic [5:0] I_P3_PIN,
	output logic [5:0] O_P3_OUT,
	output logic [5:0] O_P3_OE,
	output logic [5:0] O_P3_PULLUP,
	output logic O_CARRIER_ON,
	input wire logic I_TIMER0_PWM_OUT,
	input wire logic I_REMOTE_CARRIER_OUT,
	output logic O_TIMER0_CAPTURE_IN,
	output logic O_TIMER1_CAPTURE_IN,
	output logic O_TIMER2_CAPTURE_IN,
	output logic O_TIMER0_EXT_CLOCK_IN,
	output logic O_PIN45_P4_SELECT
);
	ppf_byte_t p2_pullup;
	ppf_byte_t p3_ctrl;
	ppf_byte_t p3_latch;
	ppf_byte_t p3_pin45;
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;

	wire logic sel_p2;
	wire logic sel_p3d;
	wire logic sel_p3c;
	wire logic sel_p45;
	wire logic wr_p2;
	wire logic wr_p3d;
	wire logic wr_p3c;
	wire logic wr_p45;
	wire logic any_sel;
	wire ppf_byte_t next_p2_pullup;
	wire ppf_byte_t next_p3_ctrl;
	wire ppf_byte_t next_p3_latch;
	wire ppf_byte_t next_p3_pin45;
	wire ppf_byte_t next_rdata;
	wire logic next_hit;
	wire logic small_pkg;
	wire logic p0_alt;
	wire logic p1_alt;
	wire ppf_mode_t mode [0:5];
	wire logic [5:0] alt_en;
	wire logic [5:0] alt_data;
	wire logic [5:0] is_out;
	wire logic [5:0] drv_pu;
	wire ppf_byte_t p3_read;
	wire ppf_byte_t rd_mux;

	assign sel_p2 = (I_REG_ADDR == `PPF_ADDR_P2_PULLUP)
		& (I_REG_BANK == `PPF_BANK_P2_PULLUP); // [R2]
	assign sel_p3d = (I_REG_ADDR == `PPF_ADDR_P3_DATA)
		& (I_REG_BANK == `PPF_BANK_P3_DATA); // [R7]
	assign sel_p3c = (I_REG_ADDR == `PPF_ADDR_P3_CTRL)
		& (I_REG_BANK == `PPF_BANK_P3_CTRL);
	assign sel_p45 = (I_REG_ADDR == `PPF_ADDR_P3_PIN45)
		& (I_REG_BANK == `PPF_BANK_P3_PIN45); // [R10]

	// Each write strobe is qualified by its own address decode.
	assign wr_p2 = I_REG_WR & sel_p2; // [R2]
	assign wr_p3d = I_REG_WR & sel_p3d; // [R7]
	assign wr_p3c = I_REG_WR & sel_p3c;
	assign wr_p45 = I_REG_WR & sel_p45; // [R10]
	// A read of an unmapped address returns zero with the hit flag low.
	assign any_sel = sel_p2 | sel_p3d | sel_p3c | sel_p45;
	assign next_p2_pullup = wr_p2 ? I_REG_WDATA : p2_pullup; // [R2]
	assign next_p3_ctrl = wr_p3c ? I_REG_WDATA : p3_ctrl; // [R12]
	// Bit 6 has no storage behind it, so it never holds a one.
	assign next_p3_latch = wr_p3d ? (I_REG_WDATA & `PPF_DATA_MASK)
		: p3_latch; // [R7] [R8]
	// Reserved bits of the pin 4/5 register never take a one.
	assign next_p3_pin45 = wr_p45 ? (I_REG_WDATA & `PPF_PIN45_MASK)
		: p3_pin45; // [R10]

	// Registers update on the write edge and steer the pins right after.
	always_ff @(posedge I_REF_CLK or posedge I_RST)
	begin
		if (I_RST)
			p2_pullup <= `PPF_RST_P2_PULLUP; // [R12]
		else
			p2_pullup <= next_p2_pullup; // [R2] [R12]
	end

	always_ff @(posedge I_REF_CLK or posedge I_RST)
	begin
		if (I_RST)
			p3_ctrl <= `PPF_RST_P3_CTRL; // [R12]
		else
			p3_ctrl <= next_p3_ctrl; // [R12]
	end

	always_ff @(posedge I_REF_CLK or posedge I_RST)
	begin
		if (I_RST)
			p3_latch <= `PPF_RST_P3_DATA;
		else
			p3_latch <= next_p3_latch; // [R7]
	end

	always_ff @(posedge I_REF_CLK or posedge I_RST)
	begin
		if (I_RST)
			p3_pin45 <= `PPF_RST_P3_PIN45; // [R11]
		else
			p3_pin45 <= next_p3_pin45; // [R10]
	end

	// Pins come from outside the clock domain, so two stages first.
	always_ff @(posedge I_REF_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			pin_meta <= 6'h00;
			pin_sync <= 6'h00;
		end
		else
		begin
			pin_meta <= I_P3_PIN;
			pin_sync <= pin_meta;
		end
	end

	assign O_P2_PULLUP = p2_pullup; // [R1]
	assign O_CARRIER_ON = p3_latch[`PPF_DATA_CARRIER]; // [R7]
	assign O_PIN45_P4_SELECT = p3_pin45[0];

	assign small_pkg = (p3_ctrl[`PPF_CTRL_PKG_HI:`PPF_CTRL_PKG_LO]
		== `PPF_PKG_SMALL); // [R4]
	assign p0_alt = p3_ctrl[`PPF_CTRL_P0_FUNC]; // [R5]
	assign p1_alt = p3_ctrl[`PPF_CTRL_P1_FUNC]; // [R5]

	assign mode[0] = p3_ctrl[`PPF_CTRL_P0_MODE_HI:`PPF_CTRL_P0_MODE_LO]; // [R6]
	assign mode[1] = p3_ctrl[`PPF_CTRL_P1_MODE_HI:`PPF_CTRL_P1_MODE_LO]; // [R6]
	assign mode[2] = `PPF_MODE_IN_PU; // [R3]
	assign mode[3] = `PPF_MODE_IN_PU; // [R3]
	assign mode[4] = p3_pin45[5:4]; // [R10]
	assign mode[5] = p3_pin45[7:6]; // [R10]

	// Output modes carry the timer and remote outputs when selected.
	assign alt_en = {4'h0, p1_alt, p0_alt}; // [R5]
	assign alt_data = {4'h0, I_REMOTE_CARRIER_OUT, I_TIMER0_PWM_OUT}; // [R4]

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1)
		begin : g_pin
			ppf_pin_drive u_drv (
				.i_mode(mode[gi]),
				.i_data(p3_latch[gi]),
				.i_alt_en(alt_en[gi]),
				.i_alt_data(alt_data[gi]),
				.o_out(O_P3_OUT[gi]),
				.o_oe(O_P3_OE[gi]),
				.o_pullup(drv_pu[gi]),
				.o_is_output(is_out[gi])
			);
		end
	endgenerate

	assign O_P3_PULLUP = drv_pu; // [R3] [R6]

	// Inputs reach the timers only when their function is selected.
	assign O_TIMER0_CAPTURE_IN = p0_alt & ~is_out[0] & pin_sync[0]; // [R4] [R5]
	assign O_TIMER1_CAPTURE_IN = p0_alt
		& (small_pkg ? (~is_out[0] & pin_sync[0]) : pin_sync[3]); // [R4]
	assign O_TIMER2_CAPTURE_IN = p0_alt & ~small_pkg & pin_sync[3]; // [R4]
	assign O_TIMER0_EXT_CLOCK_IN = p1_alt
		& (small_pkg ? (~is_out[1] & pin_sync[1]) : pin_sync[2]); // [R4]

	// Bit 6 reads zero; pin bits show the pad level in every mode.
	assign p3_read = {p3_latch[`PPF_DATA_CARRIER], 1'b0,
		pin_sync}; // [R8] [R9]

	assign rd_mux = sel_p2 ? p2_pullup :
		sel_p3d ? p3_read :
		sel_p3c ? p3_ctrl :
		sel_p45 ? p3_pin45 : 8'h00;

	// Read data change only on a read strobe and hold until the next one.
	assign next_rdata = I_REG_RD ? rd_mux : O_REG_RDATA;
	assign next_hit = I_REG_RD ? any_sel : O_REG_HIT;

	always_ff @(posedge I_REF_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			O_REG_RDATA <= 8'h00;
			O_REG_HIT <= 1'b0;
		end
		else
		begin
			O_REG_RDATA <= next_rdata; // [R2]
			O_REG_HIT <= next_hit; // [R2]
		end
	end
endmodule

//--- ppf_port_cfg_asserts.sv
// Checker for the register and pad rules of the port configuration block.
// Assumes it is bound to ppf_port_cfg and sees only its ports.
module ppf_port_cfg_asserts (
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic I_REG_BANK,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [7:0] I_REG_WDATA,
	input wire logic [7:0] O_REG_RDATA,
	input wire logic O_REG_HIT,
	input wire logic [7:0] O_P2_PULLUP,
	input wire logic [5:0] O_P3_PULLUP,
	input wire logic O_CARRIER_ON
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [8:0] ra = {I_REG_BANK, I_REG_ADDR};
	wire sp2 = ra == 9'h0ee;
	wire sdt = ra == 9'h0e3;
	wire map = ra inside {9'h0ee, 9'h0e3, 9'h0ef, 9'h1e1};
	default clocking @(posedge I_REF_CLK);
	endclocking
	default disable iff (I_RST);
	a_p3_fixed_pu: assert property (O_P3_PULLUP[3:2] == 2'b11)
		else $error("pins 2 3 pull-up off");
	a_p2_write: assert property (I_REG_WR && sp2
		|=> O_P2_PULLUP == $past(I_REG_WDATA)) else $error("pull-up write");
	a_p2_hold: assert property (!(I_REG_WR && sp2)
		|=> $stable(O_P2_PULLUP)) else $error("pull-up moved");
	a_p2_readback: assert property (I_REG_RD && sp2
		|=> O_REG_RDATA == $past(O_P2_PULLUP)) else $error("pull-up read");
	a_carrier_write: assert property (I_REG_WR && sdt
		|=> O_CARRIER_ON == $past(I_REG_WDATA[7])) else $error("carrier");
	a_bit6_zero: assert property (I_REG_RD && sdt
		|=> !O_REG_RDATA[6]) else $error("data bit 6 set");
	a_unmapped_read: assert property (I_REG_RD && !map
		|=> !O_REG_HIT && O_REG_RDATA == 8'h00) else $error("unmapped read");
	a_read_hold: assert property (!I_REG_RD
		|=> $stable(O_REG_RDATA) && $stable(O_REG_HIT)) else $error("rd moved");
	cover property (I_REG_WR && sp2);
	cover property (I_REG_RD && !map);
	cover property ($rose(O_CARRIER_ON));
endmodule

//--- tb_top.sv
// Self-checking bench for the port configuration block.
// Assumes the design, its header and the checker are compiled first.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
`define CK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t %h %h", $time, a, e); end end
	logic clk = 0, rst, wr = 0, rd = 0, bk = 0, pwm = 0, remote_carrier_out = 0;
	logic [7:0] ad = 0, wd = 0, q;
	logic [5:0] pin = 0;
	wire [7:0] rdat, p2;
	wire [5:0] oe, pu, out;
	wire hit, car, tc0, tc1, tc2, tck, p4s;
	int seed = 27, miscompares = 0, comparisons = 0, cyc = 0, k, m[int];
	logic [8:0] al[6] = '{9'h0ee, 9'h0e3, 9'h0ef, 9'h1e1, 9'h0e0, 9'h1ee};
	always #50 clk = ~clk;
	ppf_port_cfg ppf_port_cfg_inst (.I_REF_CLK(clk), .I_RST(rst),
		.I_REG_ADDR(ad), .I_REG_BANK(bk), .I_REG_WR(wr), .I_REG_RD(rd),
		.I_REG_WDATA(wd), .O_REG_RDATA(rdat), .O_REG_HIT(hit),
		.O_P2_PULLUP(p2), .I_P3_PIN(pin), .O_P3_OUT(out), .O_P3_OE(oe),
		.O_P3_PULLUP(pu), .O_CARRIER_ON(car), .I_TIMER0_PWM_OUT(pwm),
		.I_REMOTE_CARRIER_OUT(remote_carrier_out), .O_TIMER0_CAPTURE_IN(tc0),
		.O_TIMER1_CAPTURE_IN(tc1), .O_TIMER2_CAPTURE_IN(tc2),
		.O_TIMER0_EXT_CLOCK_IN(tck), .O_PIN45_P4_SELECT(p4s));
	task end_sim;
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wr_t(input logic [8:0] a, input logic [7:0] d);
		@(negedge clk);
		{bk, ad} = a;
		wd = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
		if (m.exists(a))
			m[a] = d;
	endtask
	task rd_t(input logic [8:0] a);
		@(negedge clk);
		{bk, ad} = a;
		rd = 1;
		@(negedge clk);
		rd = 0;
		q = !m.exists(a) ? 8'h00 : a == 9'h0e3 ? {m[a][7], 1'b0, pin} :
			a == 9'h1e1 ? 8'(m[a]) & 8'hf1 : 8'(m[a]);
		`CK(rdat, q)
		`CK(hit, 1'(m.exists(a)))
	endtask
	// Pad and timer model built from the register model and the pins.
	task chk_pads;
		logic [7:0] c, h, d;
		logic [1:0] md;
		logic [5:0] eo, ee, ep;
		logic v, sm, i0, i1;
		int j;
		c = 8'(m[9'h0ef]);
		h = 8'(m[9'h1e1]);
		d = 8'(m[9'h0e3]);
		sm = c[7:6] == 2'b00;
		i0 = c[1:0] == 2'b00 || c[1:0] == 2'b11;
		i1 = c[4:3] == 2'b00 || c[4:3] == 2'b11;
		for (j = 0; j < 6; j++)
		begin
			md = j == 0 ? c[1:0] : j == 1 ? c[4:3] : j == 4 ? h[5:4] :
				j == 5 ? h[7:6] : 2'b11;
			v = (j == 0 && c[2]) ? pwm : (j == 1 && c[5]) ? remote_carrier_out : d[j];
			eo[j] = md == 2'b10 && v;
			ee[j] = md == 2'b10 || (md == 2'b01 && !v);
			ep[j] = md == 2'b11;
		end
		`CK(out, eo)
		`CK(oe, ee)
		`CK(pu, ep)
		`CK(p4s, h[0])
		`CK(tc0, c[2] & i0 & pin[0])
		`CK(tc1, c[2] & (sm ? i0 & pin[0] : pin[3]))
		`CK(tc2, c[2] & !sm & pin[3])
		`CK(tck, c[5] & (sm ? i1 & pin[1] : pin[2]))
	endtask
	task rst_t;
		rst = 1;
		m[9'h0ee] = 0;
		m[9'h0e3] = 0;
		m[9'h0ef] = 0;
		m[9'h1e1] = 8'h50;
		repeat (20) @(negedge clk);
		rst = 0;
		repeat (2) @(negedge clk);
		`CK(p2, 8'h00)
		`CK(rdat, 8'h00)
		`CK(pu[3:2], 2'b11)
		chk_pads;
		foreach (al[i])
			rd_t(al[i]);
	endtask
	initial
	begin
		rst_t;
		for (k = 0; k < 4; k++)
		begin
			wr_t(9'h0ef, 8'(k * 9));
			`CK(oe[1:0], {2{k == 1 || k == 2}})
			`CK(pu[1:0], {2{k == 3}})
		end
		repeat (60)
		begin
			pin = 6'($random(seed));
			{pwm, remote_carrier_out} = 2'($random(seed));
			wr_t(al[{$random(seed)} % 6], 8'($random(seed)));
			`CK(p2, 8'(m[9'h0ee]))
			`CK(car, m[9'h0e3][7])
			chk_pads;
			rd_t(al[{$random(seed)} % 6]);
		end
		pin = 6'($random(seed));
		rst_t;
		end_sim;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 1000)
		begin
			miscompares++;
			end_sim;
		end
	end
endmodule
bind ppf_port_cfg ppf_port_cfg_asserts ppf_port_cfg_asserts_inst (
	.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_REG_ADDR(I_REG_ADDR),
	.I_REG_BANK(I_REG_BANK), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
	.I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
	.O_REG_HIT(O_REG_HIT), .O_P2_PULLUP(O_P2_PULLUP),
	.O_P3_PULLUP(O_P3_PULLUP), .O_CARRIER_ON(O_CARRIER_ON));
